// >>> efm_top.sv
/*
 encoder feedback monitor: wishbone registers, pulse decoding, speed
 window, loss and signal faults, stall and slip accumulation, pole search.
 assumes classic wishbone master, inputs synchronous to ref_clk_i.
*/
`timescale 1ns/10ps
`include "efm_consts.svh"
module efm_top #(
	parameter int TICK_CYC = `EFM_CLK_HZ / 1000 * `EFM_TICK_MS,
	parameter int SHORT_CYC = `EFM_CLK_HZ / 1000 * `EFM_SHORT_MS,
	parameter int PWRUP_CYC = `EFM_CLK_HZ / 1000 * `EFM_PWRUP_MS
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// encoder side
	input wire efm_pkg::efm_enc_s enc_i,
	input wire logic [15:0] serial_pos_i,
	input wire logic serial_valid_i,
	output logic serial_req_o,
	// drive side
	input wire logic run_i,
	input wire logic run_rev_i,
	input wire logic [15:0] cmd_rpm_i,
	input wire logic [2:0] pole_est_i,
	output logic short_pattern_o,
	output efm_pkg::efm_act_s act_o,
	output logic [31:0] pos_o,
	output logic [15:0] speed_cnt_o,
	output logic [15:0] pole_pos_o,
	output logic pole_done_o,
	output logic run_ready_o
);
	import efm_pkg::*;

	// ==========================================
	// register bus
	logic [31:0] cfg_q, ppr_q, det_q, stall_q, slipt_q, slipp_q, maxrpm_q;
	logic [31:0] rdata;
	logic [2:0] flt_q, flt_set, flt_clr;
	logic wr, start_q;
	logic sig_seen_q, stall_c, slip_c;
	efm_pole_e pole_q;

	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel, input logic [31:0] msk);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r & msk;
	endfunction

	// writes land on the edge at which the master sees ack, not one edge earlier
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			cfg_q <= `EFM_RST_CFG;
			ppr_q <= `EFM_RST_PPR;
			det_q <= `EFM_RST_DET;
			stall_q <= `EFM_RST_STALL;
			slipt_q <= `EFM_RST_SLIPT;
			slipp_q <= `EFM_RST_SLIPP;
			maxrpm_q <= `EFM_RST_MAXRPM;
		end else if (wr) begin
			unique case (wb_adr_i)
				`EFM_OFS_CFG: cfg_q <= wmerge(cfg_q, wb_dat_i, wb_sel_i, `EFM_MSK_CFG);
				`EFM_OFS_PPR: ppr_q <= wmerge(ppr_q, wb_dat_i, wb_sel_i, `EFM_MSK_PPR);
				`EFM_OFS_DET: det_q <= wmerge(det_q, wb_dat_i, wb_sel_i, `EFM_MSK_7);
				`EFM_OFS_STALL: stall_q <= wmerge(stall_q, wb_dat_i, wb_sel_i, `EFM_MSK_7);
				`EFM_OFS_SLIPT: slipt_q <= wmerge(slipt_q, wb_dat_i, wb_sel_i, `EFM_MSK_SLIPT);
				`EFM_OFS_SLIPP: slipp_q <= wmerge(slipp_q, wb_dat_i, wb_sel_i, `EFM_MSK_SLIPP);
				`EFM_OFS_MAXRPM: maxrpm_q <= wmerge(maxrpm_q, wb_dat_i, wb_sel_i, `EFM_MSK_MAXRPM);
				default: begin
				end
			endcase
		end
	end

	// pole search start is a self-clearing command bit
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			start_q <= 1'b0;
		end else begin
			start_q <= wr && wb_adr_i == `EFM_OFS_CMD && wb_sel_i[0] && wb_dat_i[0];
		end
	end

	always_comb begin
		unique case (wb_adr_i)
			`EFM_OFS_CFG: rdata = cfg_q;
			`EFM_OFS_PPR: rdata = ppr_q;
			`EFM_OFS_DET: rdata = det_q;
			`EFM_OFS_STALL: rdata = stall_q;
			`EFM_OFS_SLIPT: rdata = slipt_q;
			`EFM_OFS_SLIPP: rdata = slipp_q;
			`EFM_OFS_MAXRPM: rdata = maxrpm_q;
			`EFM_OFS_STAT: rdata = {22'h0, pole_q, slip_c, stall_c, run_ready_o,
				pole_done_o, sig_seen_q, flt_q};
			`EFM_OFS_SPEED: rdata = {pole_pos_o, speed_cnt_o};
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
			wb_dat_o <= rdata;
		end
	end

	a_ack_single: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held for two cycles");

	// ==========================================
	// decoding and position
	efm_ptype_e ptype;
	efm_stype_e stype;
	efm_treat_e treat;
	logic step, dir_fwd, a_rise, illegal, dec_on;

	assign ptype = efm_ptype_e'(cfg_q[`EFM_CFG_PTYPE]);
	assign stype = efm_stype_e'(cfg_q[`EFM_CFG_STYPE]);
	assign treat = efm_treat_e'(cfg_q[`EFM_CFG_TREAT]);
	assign dec_on = ptype != PT_OFF;

	efm_decoder u_dec (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.a_i(enc_i.a),
		.b_i(enc_i.b),
		.rev_cmd_i(run_rev_i),
		.ptype_i(ptype),
		.step_o(step),
		.dir_fwd_o(dir_fwd),
		.a_rise_o(a_rise),
		.illegal_o(illegal)
	);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			pos_o <= 32'h0000_0000;
		end else if (step) begin
			pos_o <= dir_fwd ? pos_o + 32'h1 : pos_o - 32'h1;
		end
	end

	a_pos_fwd: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		step && dir_fwd |=> pos_o == $past(pos_o) + 32'h1) else $error("position missed step");

	// ==========================================
	// speed window of 0.1 s
	logic [25:0] tick_q;
	logic tick;
	logic [15:0] win_q;

	assign tick = tick_q == 26'(TICK_CYC - 1);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			tick_q <= 26'h0;
		end else begin
			tick_q <= tick ? 26'h0 : tick_q + 26'h1;
		end
	end

	// counter saturates so a runaway input reads as full scale, not wrap
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			win_q <= 16'h0;
			speed_cnt_o <= 16'h0;
		end else if (tick) begin
			win_q <= {15'h0, a_rise};
			speed_cnt_o <= win_q;
		end else if (a_rise && win_q != 16'hFFFF) begin
			win_q <= win_q + 16'h1;
		end
	end

	// ==========================================
	// stall and slip comparison, command and max speed scaled by pulses per revolution
	logic [39:0] fb_x, cmd_x, base_x, diff_x;

	always_comb begin
		fb_x = 40'(speed_cnt_o) * `EFM_WIN_PER_MIN;
		cmd_x = 40'(cmd_rpm_i) * 40'(ppr_q[14:0]);
		base_x = 40'(maxrpm_q[15:0]) * 40'(ppr_q[14:0]);
		diff_x = fb_x > cmd_x ? fb_x - cmd_x : cmd_x - fb_x;
		stall_c = dec_on && stall_q[6:0] != 7'h0 &&
			fb_x * `EFM_PCT > 40'(stall_q[6:0]) * base_x;
		slip_c = dec_on && run_i && slipp_q[5:0] != 6'h0 &&
			diff_x * `EFM_PCT > 40'(slipp_q[5:0]) * base_x;
	end

	a_stall_off: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		stall_q[6:0] == 7'h0 |-> !stall_c) else $error("stall check with level zero");

	// ==========================================
	// loss, signal and setting errors
	logic loss_q, ill_win_q, set_err, det_trip, slip_trip;

	assign set_err = dec_on && (ppr_q[14:0] == 15'h0 || ppr_q[14:0] > `EFM_PPR_MAX ||
		cfg_q[6:4] > 3'h5);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			loss_q <= 1'b0;
			ill_win_q <= 1'b0;
			sig_seen_q <= 1'b0;
		end else if (tick) begin
			loss_q <= dec_on && run_i && cmd_rpm_i != 16'h0 && win_q == 16'h0;
			sig_seen_q <= ill_win_q | illegal;
			ill_win_q <= 1'b0;
		end else if (illegal) begin
			ill_win_q <= 1'b1;
		end
	end

	efm_accum #(.W(7)) u_det (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.tick_i(tick),
		.cond_i(loss_q | sig_seen_q | set_err),
		.hold_i(1'b0),
		.limit_i(det_q[6:0]),
		.trip_o(det_trip)
	);

	efm_accum #(.W(5)) u_slip (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.tick_i(tick),
		.cond_i(slip_c | stall_c),
		.hold_i(run_i),
		.limit_i(slipt_q[4:0]),
		.trip_o(slip_trip)
	);

	// ==========================================
	// fault flags, set beats a same-cycle clear
	assign flt_set = {slip_trip, det_trip & (sig_seen_q | set_err), det_trip & loss_q};
	assign flt_clr = (wr && wb_adr_i == `EFM_OFS_STAT && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			flt_q <= 3'h0;
		end else begin
			flt_q <= (flt_q & ~flt_clr) | flt_set;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			act_o <= '0;
		end else begin
			act_o.warn <= flt_q != 3'h0;
			act_o.ramp <= flt_q != 3'h0 && treat == TR_RAMP;
			act_o.coast <= flt_q != 3'h0 && treat != TR_KEEP && treat != TR_RAMP;
		end
	end

	a_treat_coast: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		flt_q != 3'h0 && treat == TR_COAST |=> act_o.coast && act_o.warn && !act_o.ramp)
		else $error("coast treatment not applied");
	a_slip_fault: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		slip_trip |=> flt_q[2]) else $error("slip trip did not raise stall fault");

	// ==========================================
	// magnetic pole search
	logic [23:0] short_q;
	logic [25:0] pwr_q;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			pole_q <= PL_IDLE;
			short_q <= 24'h0;
			pole_pos_o <= 16'h0;
		end else begin
			unique case (pole_q)
				PL_IDLE, PL_DONE: begin
					if (start_q) begin
						unique case (stype)
							ST_QUAD, ST_ANALOG: begin
								pole_q <= PL_SHORT;
								short_q <= 24'h0;
							end
							ST_HALL: begin
								pole_pos_o <= {enc_i.commutation_channels, 13'h0};
								pole_q <= PL_DONE;
							end
							ST_SINE: begin
								pole_pos_o <= {enc_i.sin_pos, enc_i.cos_pos, 14'h0};
								pole_q <= PL_DONE;
							end
							ST_SER_A, ST_SER_B: pole_q <= PL_SER;
							default: pole_q <= PL_IDLE;
						endcase
					end
				end
				PL_SHORT: begin
					if (short_q == 24'(SHORT_CYC - 1)) begin
						pole_pos_o <= {pole_est_i, 13'h0};
						pole_q <= PL_DONE;
					end else begin
						short_q <= short_q + 24'h1;
					end
				end
				PL_SER: begin
					if (serial_valid_i) begin
						pole_pos_o <= serial_pos_i;
						pole_q <= PL_DONE;
					end
				end
			endcase
		end
	end

	assign short_pattern_o = pole_q == PL_SHORT;
	assign serial_req_o = pole_q == PL_SER;
	assign pole_done_o = pole_q == PL_DONE;

	// serial encoders need time to come up before a run is allowed
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			pwr_q <= 26'h0;
		end else if (pwr_q != 26'(PWRUP_CYC)) begin
			pwr_q <= pwr_q + 26'h1;
		end
	end

	assign run_ready_o = (stype != ST_SER_A && stype != ST_SER_B) ||
		pwr_q == 26'(PWRUP_CYC);

	a_short_type: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(short_pattern_o) |-> $past(stype) == ST_QUAD || $past(stype) == ST_ANALOG)
		else $error("short pattern for wrong signal type");
	a_hall_pole: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		start_q && stype == ST_HALL && pole_q != PL_SHORT && pole_q != PL_SER
		|=> pole_pos_o[15:13] == $past(enc_i.commutation_channels) && pole_done_o)
		else $error("commutation pole not captured");
	a_ser_ready: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(stype == ST_SER_A || stype == ST_SER_B) && pwr_q < 26'(PWRUP_CYC) |-> !run_ready_o)
		else $error("run ready before power-up delay");
endmodule

// >>> efm_consts.svh
/*
 constants of the encoder feedback monitor: offsets, resets, fields, timing.
 assumes a 25 MHz control clock and word-aligned classic wishbone access.
*/
// How it works
// - quadrature type one: A leads means forward
// - quadrature type two: B leads means forward
// - pulse type three: B high forward
// - pulse type four: B low forward
// - pulses per revolution 1..20000, default 600
// - fault treatment keep, ramp, coast; default coast
// - feedback error beyond detection time raises fault
// - stall above percent of max frequency
// - slip accumulation limit 0..2.0 s, default 0.1
// - slip threshold 0..50 percent, zero disables
// - types 1,5: short pattern finds pole
// - type 2: commutation channels give pole
// - type 3: sine cosine track gives pole
// - types 4,6: serial channel gives pole
// - accumulate slip or stall time, then fault
// - slip is speed minus commanded speed; code uses the absolute difference
`ifndef EFM_CONSTS_SVH
`define EFM_CONSTS_SVH
// ==========================================
// register map
`define EFM_OFS_CFG 8'h00
`define EFM_OFS_PPR 8'h04
`define EFM_OFS_DET 8'h08
`define EFM_OFS_STALL 8'h0C
`define EFM_OFS_SLIPT 8'h10
`define EFM_OFS_SLIPP 8'h14
`define EFM_OFS_MAXRPM 8'h18
`define EFM_OFS_CMD 8'h1C
`define EFM_OFS_STAT 8'h20
`define EFM_OFS_SPEED 8'h24
// ==========================================
// reset values and writable masks
`define EFM_RST_CFG 32'h0000_0200
`define EFM_RST_PPR 32'h0000_0258
`define EFM_RST_DET 32'h0000_000A
`define EFM_RST_STALL 32'h0000_0073
`define EFM_RST_SLIPT 32'h0000_0001
`define EFM_RST_SLIPP 32'h0000_0032
`define EFM_RST_MAXRPM 32'h0000_05DC
`define EFM_MSK_CFG 32'h0000_0377
`define EFM_MSK_PPR 32'h0000_7FFF
`define EFM_MSK_7 32'h0000_007F
`define EFM_MSK_SLIPT 32'h0000_001F
`define EFM_MSK_SLIPP 32'h0000_003F
`define EFM_MSK_MAXRPM 32'h0000_FFFF
// ==========================================
// fields
`define EFM_CFG_STYPE 2:0
`define EFM_CFG_PTYPE 6:4
`define EFM_CFG_TREAT 9:8
`define EFM_PPR_MAX 15'h4E20
`define EFM_WIN_PER_MIN 40'h258
`define EFM_PCT 40'h64
// ==========================================
// timing
`define EFM_CLK_HZ 25000000
`define EFM_TICK_MS 100
`define EFM_SHORT_MS 20
`define EFM_PWRUP_MS 2000
`endif

// >>> efm_pkg.sv
/*
 types of the encoder feedback monitor.
 assumes efm_consts.svh carries the numbers.
*/
package efm_pkg;
	typedef enum logic [2:0] {PT_OFF = 3'b000, PT_QUAD_A = 3'b001, PT_QUAD_B = 3'b010,
		PT_PDIR_H = 3'b011, PT_PDIR_L = 3'b100, PT_SINGLE = 3'b101} efm_ptype_e;
	typedef enum logic [2:0] {ST_NONE = 3'b000, ST_QUAD = 3'b001, ST_HALL = 3'b010,
		ST_SINE = 3'b011, ST_SER_A = 3'b100, ST_ANALOG = 3'b101,
		ST_SER_B = 3'b110} efm_stype_e;
	typedef enum logic [1:0] {PL_IDLE = 2'b00, PL_SHORT = 2'b01, PL_SER = 2'b10,
		PL_DONE = 2'b11} efm_pole_e;
	typedef enum logic [1:0] {TR_KEEP = 2'b00, TR_RAMP = 2'b01,
		TR_COAST = 2'b10} efm_treat_e;
	typedef struct packed {
		logic a;
		logic b;
		logic [2:0] commutation_channels;
		logic sin_pos;
		logic cos_pos;
	} efm_enc_s;
	typedef struct packed {
		logic warn;
		logic ramp;
		logic coast;
	} efm_act_s;
endpackage

// >>> efm_decoder.sv
/*
 pulse decoder: quadrature, pulse plus direction, single phase.
 assumes channel levels already synchronous to ref_clk_i.
*/
`timescale 1ns/10ps
module efm_decoder (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// channels and mode
	input wire logic a_i,
	input wire logic b_i,
	input wire logic rev_cmd_i,
	input wire efm_pkg::efm_ptype_e ptype_i,
	// decoded events
	output logic step_o,
	output logic dir_fwd_o,
	output logic a_rise_o,
	output logic illegal_o
);
	import efm_pkg::*;
	logic a_q, b_q, a_ch, b_ch, fwd_ab;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
		end else begin
			a_q <= a_i;
			b_q <= b_i;
		end
	end
	always_comb begin
		a_ch = a_i ^ a_q;
		b_ch = b_i ^ b_q;
		fwd_ab = a_i ^ b_q;
		a_rise_o = a_i & ~a_q & (ptype_i != PT_OFF);
		step_o = 1'b0;
		dir_fwd_o = 1'b0;
		illegal_o = 1'b0;
		unique case (ptype_i)
			PT_QUAD_A: begin
				step_o = a_ch ^ b_ch;
				dir_fwd_o = fwd_ab;
				illegal_o = a_ch & b_ch;
			end
			PT_QUAD_B: begin
				step_o = a_ch ^ b_ch;
				dir_fwd_o = ~fwd_ab;
				illegal_o = a_ch & b_ch;
			end
			PT_PDIR_H: begin
				step_o = a_rise_o;
				dir_fwd_o = b_i;
			end
			PT_PDIR_L: begin
				step_o = a_rise_o;
				dir_fwd_o = ~b_i;
			end
			PT_SINGLE: begin
				step_o = a_rise_o;
				dir_fwd_o = ~rev_cmd_i;
			end
			default: begin
				step_o = 1'b0;
			end
		endcase
	end
	a_off_no_step: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		ptype_i == PT_OFF |-> !step_o && !a_rise_o) else $error("step while decoding off");
	a_quad_fwd: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		ptype_i == PT_QUAD_A && !a_q && !b_q && a_i && !b_i |-> step_o && dir_fwd_o)
		else $error("A leading B not forward");
endmodule

// >>> efm_accum.sv
/*
 time accumulator in 0.1 s ticks with a trip once the limit is passed.
 assumes tick_i is a one-cycle pulse every 0.1 s.
*/
`timescale 1ns/10ps
module efm_accum #(
	parameter int W = 7
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// time base and condition
	input wire logic tick_i,
	input wire logic cond_i,
	input wire logic hold_i,
	input wire logic [W-1:0] limit_i,
	// result
	output logic trip_o
);
	logic [W:0] cnt_q;
	// hold_i keeps the total across gaps so short bursts still add up
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			cnt_q <= '0;
		end else if (!cond_i && !hold_i) begin
			cnt_q <= '0;
		end else if (cond_i && tick_i && cnt_q != {(W+1){1'b1}}) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	assign trip_o = cnt_q > {1'b0, limit_i};
	a_idle_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!cond_i && !hold_i |=> !trip_o) else $error("trip survived idle condition");
endmodule

// >>> efm_enc_model.sv
/*
 rotary encoder model: quadrature steps, pulse plus direction, pole lines,
 serial position answer.
 assumes the bench calls its tasks from a single process.
*/
`timescale 1ns/10ps
module efm_enc_model (
	// clock
	input wire logic ref_clk_i,
	// serial position request
	input wire logic serial_req_i,
	// encoder lines
	output efm_pkg::efm_enc_s enc_o,
	output logic [15:0] serial_pos_o,
	output logic serial_valid_o
);
	import efm_pkg::*;
	logic [1:0] ph_q = 2'h0;
	logic spin = 1'b0;
	int lat = 3;
	initial begin
		enc_o = '0;
		serial_pos_o = 16'h5AA5;
		serial_valid_o = 1'b0;
	end
	// ==========================================
	// quadrature: A leads when fwd; both moves two phases so A and B flip together
	task automatic step(input logic fwd, input logic both);
		logic [1:0] n;
		n = both ? ph_q + 2'h2 : (fwd ? ph_q + 2'h1 : ph_q - 2'h1);
		@(posedge ref_clk_i);
		ph_q <= n;
		enc_o.a <= n[0] ^ n[1];
		enc_o.b <= n[1];
		repeat (3) @(posedge ref_clk_i);
	endtask
	// pulse on A with the direction level on B
	task automatic pulse(input logic dir);
		@(posedge ref_clk_i);
		enc_o.b <= dir;
		repeat (2) @(posedge ref_clk_i);
		enc_o.a <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		enc_o.a <= 1'b0;
		ph_q <= {dir, dir};
		repeat (2) @(posedge ref_clk_i);
	endtask
	task automatic set_pole(input logic [2:0] u, input logic s, input logic c);
		@(posedge ref_clk_i);
		enc_o.commutation_channels <= u;
		enc_o.sin_pos <= s;
		enc_o.cos_pos <= c;
	endtask
	initial forever begin
		@(posedge ref_clk_i);
		if (spin)
			step(1'b1, 1'b0);
	end
	// ==========================================
	// serial answer after lat cycles; data turns over once valid drops
	initial forever begin
		@(posedge ref_clk_i);
		if (serial_req_i && !serial_valid_o) begin
			repeat (lat) @(posedge ref_clk_i);
			serial_pos_o <= 16'hA55A;
			serial_valid_o <= 1'b1;
			@(posedge ref_clk_i);
			serial_pos_o <= 16'h5AA5;
			serial_valid_o <= 1'b0;
		end
	end
endmodule

// >>> efm_top_tb.sv
/*
 self-checking bench of the encoder feedback monitor over wishbone.
 assumes efm_enc_model stands in for the encoder on the motor.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
	end \
end
module efm_top_tb;
	import efm_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat, pos, p0, q;
	logic ack, sval, sreq, short_o, pdone, rready, fw;
	efm_enc_s enc;
	efm_act_s act;
	logic [15:0] spos, ppos, spd;
	logic run = 1'b0;
	logic rev = 1'b0;
	logic [15:0] rpm = 16'h0;
	logic [2:0] pest = 3'h6;
	logic [31:0] dflt [7] = '{32'h200, 32'h258, 32'hA, 32'h73, 32'h1, 32'h32, 32'h5DC};
	logic [31:0] qexp [3] = '{32'h0, 32'h4, 32'hFFFF_FFFC};
	logic [2:0] aexp [3] = '{3'b100, 3'b110, 3'b101};
	logic [2:0] sexp [3] = '{3'b011, 3'b000, 3'b101};
	logic [15:0] pexp [7] = '{16'h0, 16'hC000, 16'hA000, 16'h8000, 16'hA55A, 16'hC000, 16'hA55A};
	int error_cnt = 0;
	int n_compared = 0;
	int short_n = 0;
	int k;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (short_o === 1'b1)
			short_n++;
	end
	efm_top #(.TICK_CYC(50), .SHORT_CYC(20), .PWRUP_CYC(200)) efm_top_i (
		.ref_clk_i(clk), .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.enc_i(enc), .serial_pos_i(spos), .serial_valid_i(sval), .serial_req_o(sreq),
		.run_i(run), .run_rev_i(rev), .cmd_rpm_i(rpm), .pole_est_i(pest),
		.short_pattern_o(short_o), .act_o(act), .pos_o(pos), .speed_cnt_o(spd),
		.pole_pos_o(ppos), .pole_done_o(pdone), .run_ready_o(rready));
	efm_enc_model efm_enc_model_i (.ref_clk_i(clk), .serial_req_i(sreq), .enc_o(enc),
		.serial_pos_o(spos), .serial_valid_o(sval));
	// ==========================================
	// closing and bus tasks
	task automatic report_and_stop();
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic fail_if(input bit c);
		if (c) begin
			error_cnt++;
			report_and_stop();
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		fail_if(ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask
	function automatic logic sig(input int w);
		case (w)
			0: return act.warn;
			1: return pdone;
			default: return rready;
		endcase
	endfunction
	task automatic wait_for(input int w, input int lim);
		k = 0;
		while (sig(w) !== 1'b1 && k < lim) begin
			@(posedge clk);
			k++;
		end
		fail_if(sig(w) !== 1'b1);
	endtask
	task automatic reset_dut();
		@(posedge clk);
		rst_b <= 1'b0;
		run <= 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
	endtask
	// ==========================================
	// scenarios
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		foreach (dflt[i]) rd(8'(i * 4), dflt[i]);
		`CHK(rready, 1'b1)
		rd(8'h40, 32'h0);
		wr(8'h04, 32'd20000);
		rd(8'h04, 32'd20000);
		for (int t = 0; t < 3; t++) begin
			reset_dut();
			wr(8'h00, 32'h200 | (t << 4));
			p0 = pos;
			repeat (4) efm_enc_model_i.step(1'b1, 1'b0);
			`CHK(pos - p0, qexp[t])
			efm_enc_model_i.step(1'b1, 1'b1);
			repeat (4) efm_enc_model_i.step(1'b0, 1'b0);
			`CHK(pos - p0, 32'h0)
		end
		// pulse plus direction and single phase, run command set to reverse
		for (int t = 3; t < 6; t++) begin
			for (int d = 0; d < 2; d++) begin
				reset_dut();
				wr(8'h00, 32'h200 | (t << 4));
				run <= 1'b1;
				rev <= 1'b1;
				p0 = pos;
				repeat (3) efm_enc_model_i.pulse(d[0]);
				fw = (t == 3) ? d[0] : (t == 4) ? !d[0] : 1'b0;
				`CHK({$signed(pos - p0) > 0, $signed(pos - p0) < 0}, fw ? 2'b10 : 2'b01)
			end
		end
		reset_dut();
		wr(8'h08, 32'h2);
		wr(8'h00, 32'h210);
		rpm <= 16'd100;
		run <= 1'b1;
		repeat (90) @(posedge clk);
		`CHK(act, 3'b000)
		wait_for(0, 200);
		wb(1'b0, 8'h20, 32'h0);
		`CHK(q[0], 1'b1)
		for (int t = 0; t < 3; t++) begin
			wr(8'h00, 32'h010 | (t << 8));
			repeat (2) @(posedge clk);
			`CHK(act, aexp[t])
		end
		// stall only, both off, slip only, with the motor turning fast
		for (int c = 0; c < 3; c++) begin
			reset_dut();
			wr(8'h04, 32'h1);
			wr(8'h18, 32'd100);
			wr(8'h0C, {31'h0, c == 0});
			wr(8'h14, {31'h0, c == 2});
			wr(8'h10, 32'h2);
			wr(8'h00, 32'h210);
			run <= 1'b1;
			efm_enc_model_i.spin <= 1'b1;
			repeat (300) @(posedge clk);
			wb(1'b0, 8'h20, 32'h0);
			`CHK({q[7:6], q[2]}, sexp[c])
			`CHK(spd >= 16'd2 && spd <= 16'd3, 1'b1)
			efm_enc_model_i.spin <= 1'b0;
		end
		for (int s = 1; s < 7; s++) begin
			reset_dut();
			efm_enc_model_i.lat = (s == 4) ? 0 : 6;
			efm_enc_model_i.set_pole(3'b101, 1'b1, 1'b0);
			wr(8'h00, 32'h200 | s);
			short_n = 0;
			wr(8'h1C, 32'h1);
			wait_for(1, 100);
			`CHK(short_n, (s == 1 || s == 5) ? 20 : 0)
			`CHK(ppos, pexp[s])
		end
		reset_dut();
		wr(8'h00, 32'h204);
		@(posedge clk);
		`CHK(rready, 1'b0)
		wait_for(2, 300);
		`CHK(k > 185 && k < 205, 1'b1)
		run <= 1'b1;
		report_and_stop();
	end
	initial begin
		repeat (90000) @(posedge clk);
		fail_if(1'b1);
	end
endmodule
